// File: src/sop_status1_nv.sv
// Status-one persistent register with hardware write protection
`default_nettype none

// Behaviour
// R1 - Lock bit set and protect pin low: status/config writes ignored.
// R2 - Protect pin high: status/config writes accepted regardless of lock.
// R3 - Lock bit clear: protect pin has no effect on writes.
// R4 - Protect pin never affects writes to other registers.
// R5 - Live lock bit always mirrors persistent lock bit.
// R6 - Program-error default seeds live flag; user cannot program it.
// R7 - Erase-error default seeds live flag; user cannot change it.
// R8 - Volatility select picks persistent or live protect bits.
// R9 - Select 0: write programs persistent protect bits, live follows.
// R10 - Select 1: write updates live protect bits only.
// R11 - Governing protect bit set refuses program and erase.
// R12 - Whole-array erase runs only with all governing protect bits zero.
// R13 - Switching to volatile programs persistent protect bits to ones.
// R14 - Write-latch default seeds live latch; not user programmable.
// R15 - Busy default seeds live busy flag; not user programmable.
// R16 - Register reached by write-registers, read-any and write-any.
// R17 - Reset copies each persistent register into its live copy.
// R18 - Programming persistent bits refreshes the live copy; the ones set on switching to volatile do not reach the live protect bits.
// R19 - Rejected write leaves all status and config bits unchanged.
module sop_status1_nv
   import sop_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire sop_cmd_type i_cmd,
   input wire logic i_write_protect_n,
   input wire logic i_array_op_req,
   output logic [7:0] o_status_persist,
   output logic [7:0] o_status_live,
   output logic [7:0] o_config_persist,
   output logic [7:0] o_config_live,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_wr_rejected,
   output logic o_erase_go,
   output logic o_erase_refused,
   output logic o_array_op_refused
);
   // ****************************************************************
   // State
   // ****************************************************************
   sop_state_type state_q;
   sop_state_type state_d;
   logic array_refused_q;
   logic array_refused_d;

   // Persistent cells survive reset; all four copies reload from them
   logic [7:0] nv_status_q;
   logic [7:0] nv_config_q;

   // Limitation: sector ranges are not decoded here, so any set
   // governing protect bit refuses every array operation.
   // Error, latch and busy bits are only seeded from the persistent
   // copy; their live updates belong to the operation engine.
   // Trade-off: one cycle of reload latency keeps the cells clocked.

   function automatic logic [2:0] gov_prot(input logic [7:0] sp,
                                           input logic [7:0] sl,
                                           input logic [7:0] cp);
      gov_prot = cp[VOLSEL_BIT] ? sl[PROT_HI:PROT_LO]
                                : sp[PROT_HI:PROT_LO]; // [R8]
   endfunction : gov_prot

   // ****************************************************************
   // Command decoding
   // ****************************************************************
   // Either write opcode counts as a register write
   function automatic logic f_is_write(input sop_cmd_type c);
      logic by_regs;
      logic by_any;
      by_regs = c.opcode == OP_WRITE_REGS;
      by_any = c.opcode == OP_WRITE_ANY;
      f_is_write = c.valid && (by_regs || by_any); // [R16]
   endfunction : f_is_write

   // Read-any answers from any of the four copies
   function automatic logic f_is_read(input sop_cmd_type c);
      f_is_read = c.valid && c.opcode == OP_READ_ANY; // [R16]
   endfunction : f_is_read

   // Erase is gated on the governing bits only
   function automatic logic f_is_erase(input sop_cmd_type c);
      f_is_erase = c.valid && c.opcode == OP_WHOLE_ERASE; // [R12]
   endfunction : f_is_erase

   // Both write opcodes only reach status one and config one here,
   // so every write is one that the pin lock may stop
   function automatic logic f_hits_s1c1(input sop_cmd_type c);
      logic by_regs;
      logic by_any;
      by_regs = c.opcode == OP_WRITE_REGS;
      by_any = c.opcode == OP_WRITE_ANY;
      f_hits_s1c1 = by_regs || by_any; // [R4]
   endfunction : f_hits_s1c1

   // Write-registers always carries the persistent status byte
   function automatic logic f_hits_sp(input sop_cmd_type c);
      logic by_regs;
      logic by_sel;
      by_regs = c.opcode == OP_WRITE_REGS;
      by_sel = c.sel == SEL_STATUS1_PERSIST;
      f_hits_sp = by_regs || by_sel;
   endfunction : f_hits_sp

   function automatic logic f_hits_sl(input sop_cmd_type c);
      logic by_any;
      logic by_sel;
      by_any = c.opcode == OP_WRITE_ANY;
      by_sel = c.sel == SEL_STATUS1_LIVE;
      f_hits_sl = by_any && by_sel;
   endfunction : f_hits_sl

   // Write-registers reaches config one only with its second byte
   function automatic logic f_hits_cp(input sop_cmd_type c);
      logic by_regs;
      logic by_any;
      by_regs = c.opcode == OP_WRITE_REGS && c.has_config;
      by_any = c.opcode == OP_WRITE_ANY && c.sel == SEL_CONFIG1_PERSIST;
      f_hits_cp = by_regs || by_any;
   endfunction : f_hits_cp

   // Only write-any reaches the live config copy on its own
   function automatic logic f_hits_cl(input sop_cmd_type c);
      logic by_any;
      logic by_sel;
      by_any = c.opcode == OP_WRITE_ANY;
      by_sel = c.sel == SEL_CONFIG1_LIVE;
      f_hits_cl = by_any && by_sel;
   endfunction : f_hits_cl

   // ****************************************************************
   // Field helpers
   // ****************************************************************
   // Lock holds only while the pin is driven low
   function automatic logic f_locked(input logic [7:0] s,
                                     input logic wp_n);
      f_locked = s[LOCK_BIT] && !wp_n; // [R1] [R2] [R3]
   endfunction : f_locked

   // Keep the protect slice in one place
   function automatic logic [2:0] f_prot(input logic [7:0] r);
      f_prot = r[PROT_HI:PROT_LO];
   endfunction : f_prot

   function automatic logic [7:0] f_put_prot(input logic [7:0] r,
                                             input logic [2:0] p);
      f_put_prot = r;
      f_put_prot[PROT_HI:PROT_LO] = p;
   endfunction : f_put_prot

   // Mask built from the field position, so no bit number is kept
   function automatic logic [7:0] f_volsel_mask();
      f_volsel_mask = '0;
      f_volsel_mask[VOLSEL_BIT] = 1'b1;
   endfunction : f_volsel_mask

   // All four selector codes are legal, so no default
   function automatic logic [7:0] f_read_mux(input logic [1:0] s,
                                             input logic [7:0] rsp,
                                             input logic [7:0] rsl,
                                             input logic [7:0] rcp,
                                             input logic [7:0] rcl);
      unique case (s)
         SEL_STATUS1_PERSIST: f_read_mux = rsp;
         SEL_STATUS1_LIVE: f_read_mux = rsl;
         SEL_CONFIG1_PERSIST: f_read_mux = rcp;
         SEL_CONFIG1_LIVE: f_read_mux = rcl;
      endcase
   endfunction : f_read_mux

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic is_write;
   logic is_read;
   logic is_erase;
   logic hits_s1c1;
   logic hit_sp;
   logic hit_sl;
   logic hit_cp;
   logic hit_cl;
   logic locked;
   logic vol_now;
   logic vol_req;
   logic [2:0] gov;
   logic [2:0] data_prot;
   logic [7:0] sp;
   logic [7:0] sl;
   logic [7:0] cp;
   logic [7:0] cl;
   logic [2:0] new_prot;
   logic [2:0] live_prot;

   always_comb begin
      state_d = state_q;
      state_d.rd_valid = 1'b0;
      state_d.wr_rejected = 1'b0;
      state_d.erase_go = 1'b0;
      state_d.erase_refused = 1'b0;
      sp = state_q.status_persist;
      sl = state_q.status_live;
      cp = state_q.config_persist;
      cl = state_q.config_live;
      new_prot = f_prot(sp);
      live_prot = f_prot(sl);
      data_prot = f_prot(i_cmd.status_data);

      // Decode once; every branch below reads these
      is_write = f_is_write(i_cmd); // [R16]
      is_read = f_is_read(i_cmd); // [R16]
      is_erase = f_is_erase(i_cmd); // [R12]
      hits_s1c1 = f_hits_s1c1(i_cmd); // [R4]
      hit_sp = f_hits_sp(i_cmd);
      hit_sl = f_hits_sl(i_cmd);
      hit_cp = f_hits_cp(i_cmd);
      hit_cl = f_hits_cl(i_cmd);
      locked = f_locked(sp, i_write_protect_n); // [R1] [R2] [R3]
      vol_now = cp[VOLSEL_BIT];
      vol_req = i_cmd.config_data[VOLSEL_BIT];

      // Protection is judged on the copies before this edge's write
      gov = gov_prot(sp, sl, cp); // [R8]
      array_refused_d = i_array_op_req && (gov != PROT_NONE); // [R11]

      if (is_write && hits_s1c1 && locked) begin
         // Nothing is copied into state_d, so all four copies hold
         state_d.wr_rejected = 1'b1; // [R19]
      end else if (is_write) begin
         if (hit_sp) begin
            // Protect bits frozen once the live set governs
            if (!vol_now) begin
               new_prot = data_prot; // [R9]
            end
            // Only the lock and protect bits are user bits here
            sp[LOCK_BIT] = i_cmd.status_data[LOCK_BIT];
            sp = f_put_prot(sp, new_prot); // [R6] [R7] [R14] [R15]
            sl[LOCK_BIT] = sp[LOCK_BIT]; // [R5] [R18]
            if (vol_now) begin
               live_prot = data_prot; // [R10]
            end else begin
               live_prot = new_prot; // [R9] [R18]
            end
            sl = f_put_prot(sl, live_prot);
         end else if (hit_sl) begin
            // Live protect bits are user bits only while they govern
            if (vol_now) begin
               sl = f_put_prot(sl, data_prot); // [R10]
            end
         end

         if (hit_cp) begin
            if (vol_req && !vol_now) begin
               sp = f_put_prot(sp, PROT_ALL_ONES); // [R13]
            end
            // Once set, the select stays set like the frozen bits
            cp = i_cmd.config_data | (cp & f_volsel_mask());
            cl = cp; // [R18]
         end else if (hit_cl) begin
            cl = i_cmd.config_data;
         end

         state_d.status_persist = sp;
         state_d.status_live = sl;
         state_d.config_persist = cp;
         state_d.config_live = cl;
      end else if (is_read) begin
         state_d.rd_valid = 1'b1; // [R16]
         state_d.rd_data = f_read_mux(i_cmd.sel, sp, sl, cp, cl);
      end else if (is_erase) begin
         // Any governing bit set stops the whole-array erase
         if (gov == PROT_NONE) begin
            state_d.erase_go = 1'b1; // [R12]
         end else begin
            state_d.erase_refused = 1'b1; // [R12]
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Reset reloads live copies from persistent cells captured clocked
   // The reload takes the first edge after release, so a command is
   // taken no sooner than the second edge
   logic reload_q;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state_q <= '0;
         array_refused_q <= 1'b0;
         reload_q <= 1'b1;
      end else if (reload_q) begin
         reload_q <= 1'b0;
         state_q.status_persist <= nv_status_q;
         state_q.status_live <= nv_status_q; // [R17] [R6] [R7] [R14] [R15]
         state_q.config_persist <= nv_config_q;
         state_q.config_live <= nv_config_q; // [R17]
      end else begin
         state_q <= state_d;
         array_refused_q <= array_refused_d;
      end
   end

   // ****************************************************************
   // Persistent cells
   // ****************************************************************
   // Persistent cells: not on the reset, so they hold across resets
   logic nv_init_q = 1'b0;

   always_ff @(posedge i_clk_sys) begin
      if (!nv_init_q) begin
         nv_init_q <= 1'b1;
         nv_status_q <= STATUS1_FACTORY;
         nv_config_q <= CONFIG1_FACTORY;
      end else if (!reload_q) begin
         nv_status_q <= state_d.status_persist;
         nv_config_q <= state_d.config_persist;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Every output is a register bit; no logic sits after the flops
   assign o_status_persist = state_q.status_persist;
   assign o_status_live = state_q.status_live;
   assign o_config_persist = state_q.config_persist;
   assign o_config_live = state_q.config_live;
   assign o_rd_data = state_q.rd_data;
   assign o_rd_valid = state_q.rd_valid;
   assign o_wr_rejected = state_q.wr_rejected;
   assign o_erase_go = state_q.erase_go;
   assign o_erase_refused = state_q.erase_refused;
   assign o_array_op_refused = array_refused_q;
endmodule : sop_status1_nv
`default_nettype wire

// File: src/sop_pkg.sv
// Package for the status-one persistent register and write-protect block
`default_nettype none
package sop_pkg;
   // ****************************************************************
   // Opcodes and register selectors
   // ****************************************************************
   localparam logic [7:0] OP_WRITE_REGS = 8'h01;
   localparam logic [7:0] OP_READ_ANY = 8'h65;
   localparam logic [7:0] OP_WRITE_ANY = 8'h71;
   localparam logic [7:0] OP_WHOLE_ERASE = 8'hc7;
   localparam logic [1:0] SEL_STATUS1_PERSIST = 2'h0;
   localparam logic [1:0] SEL_STATUS1_LIVE = 2'h1;
   localparam logic [1:0] SEL_CONFIG1_PERSIST = 2'h2;
   localparam logic [1:0] SEL_CONFIG1_LIVE = 2'h3;
   // ****************************************************************
   // Field positions and defaults
   // ****************************************************************
   localparam int LOCK_BIT = 7;
   localparam int PERR_BIT = 6;
   localparam int EERR_BIT = 5;
   localparam int PROT_HI = 4;
   localparam int PROT_LO = 2;
   localparam int WEL_BIT = 1;
   localparam int BUSY_BIT = 0;
   localparam int VOLSEL_BIT = 3;
   localparam logic [2:0] PROT_ALL_ONES = 3'h7;
   localparam logic [2:0] PROT_NONE = 3'h0;
   localparam logic [7:0] STATUS1_FACTORY = 8'h00;
   localparam logic [7:0] CONFIG1_FACTORY = 8'h00;
   // User-writable mask of the persistent status copy
   localparam logic [7:0] STATUS1_USER_MASK = 8'h9c;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [1:0] sel;
      logic [7:0] status_data;
      logic [7:0] config_data;
      logic has_config;
   } sop_cmd_type;

   typedef struct packed {
      logic [7:0] status_persist;
      logic [7:0] status_live;
      logic [7:0] config_persist;
      logic [7:0] config_live;
      logic [7:0] rd_data;
      logic rd_valid;
      logic wr_rejected;
      logic erase_go;
      logic erase_refused;
   } sop_state_type;
endpackage : sop_pkg
`default_nettype wire

// File: tb/sop_status1_nv_asserts.sv
// Checker for the status-one persistent block
`default_nettype none
module sop_status1_nv_asserts
   import sop_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire sop_cmd_type i_cmd,
   input wire logic i_write_protect_n,
   input wire logic i_array_op_req,
   input wire logic [7:0] o_status_persist,
   input wire logic [7:0] o_status_live,
   input wire logic [7:0] o_config_persist,
   input wire logic o_rd_valid,
   input wire logic o_wr_rejected,
   input wire logic o_erase_go,
   input wire logic o_erase_refused,
   input wire logic o_array_op_refused
);
   // *****
   // Helpers
   // *****
   logic wr, ok, write_registers_cmd;
   logic [2:0] gov;
   assign wr = i_cmd.valid && (i_cmd.opcode == OP_WRITE_REGS ||
      i_cmd.opcode == OP_WRITE_ANY);
   assign ok = i_write_protect_n || !o_status_persist[7];
   assign write_registers_cmd = i_cmd.valid && i_cmd.opcode == OP_WRITE_REGS && ok &&
      !i_cmd.has_config;
   // Governing bits follow the select, so protection is judged on them
   assign gov = o_config_persist[3] ? o_status_live[4:2] :
      o_status_persist[4:2];
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   a_lock_mirror: assert property (
      o_status_live[7] == o_status_persist[7])
      else $error("live lock differs");
   a_lock_reject: assert property (wr && !ok |=> o_wr_rejected &&
      $stable(o_status_persist) && $stable(o_config_persist)
      && $stable(o_status_live)) else $error("locked write took effect");
   a_pin_accept: assert property (wr && i_write_protect_n |=>
      !o_wr_rejected) else $error("pin high write refused");
   a_unlock_accept: assert property (wr && !o_status_persist[7]
      |=> !o_wr_rejected) else $error("unlocked write refused");
   a_fixed_bits: assert property (wr |=>
      $stable({o_status_persist[6:5], o_status_persist[1:0]}))
      else $error("default bit written");
   a_nv_protect: assert property (write_registers_cmd && !o_config_persist[3] |=>
      o_status_persist[4:2] == $past(i_cmd.status_data[4:2]) &&
      o_status_live[4:2] == o_status_persist[4:2]) else $error("nv protect");
   a_vol_protect: assert property (write_registers_cmd && o_config_persist[3] |=>
      $stable(o_status_persist[4:2]) &&
      o_status_live[4:2] == $past(i_cmd.status_data[4:2]))
      else $error("volatile protect");
   a_volsel_ones: assert property (o_config_persist[3] |->
      o_status_persist[4:2] == PROT_ALL_ONES) else $error("protect not ones");
   a_erase_gate: assert property (i_cmd.valid &&
      i_cmd.opcode == OP_WHOLE_ERASE |=> o_erase_go == ($past(gov) == 3'h0)
      && o_erase_refused != o_erase_go) else $error("erase gating");
   a_array_gate: assert property (i_array_op_req |=>
      o_array_op_refused == ($past(gov) != 3'h0)) else $error("array gating");
   a_read_pulse: assert property (i_cmd.valid &&
      i_cmd.opcode == OP_READ_ANY |=> o_rd_valid) else $error("no read data");
   c_reject: cover property (o_wr_rejected);
   c_erase: cover property (o_erase_go);
   c_refuse: cover property (o_array_op_refused);
endmodule : sop_status1_nv_asserts
bind sop_status1_nv sop_status1_nv_asserts chk_u (.i_clk_sys, .i_reset,
   .i_cmd, .i_write_protect_n, .i_array_op_req, .o_status_persist,
   .o_status_live, .o_config_persist, .o_rd_valid, .o_wr_rejected,
   .o_erase_go, .o_erase_refused, .o_array_op_refused);
`default_nettype wire

// File: tb/sop_host_model.sv
// Host-side command source for the status-one block
`default_nettype none
module sop_host_model
   import sop_pkg::*;
(
   input wire logic i_clk_sys,
   output var sop_cmd_type o_cmd
);
   initial o_cmd = '0;
   // One-cycle request; any opcode is passed through, whole-array erase included
   task automatic issue(input logic [7:0] op, input logic [1:0] sel,
      input logic [7:0] sd, input logic [7:0] cd, input logic hc);
      @(negedge i_clk_sys);
      o_cmd <= '{1'b1, op, sel, sd, cd, hc};
      @(negedge i_clk_sys);
      o_cmd <= '0;
   endtask : issue
endmodule : sop_host_model
`default_nettype wire

// File: tb/sop_status1_nv_tb_top.sv
// Testbench for the status-one persistent block
`default_nettype none
module sop_status1_nv_tb_top
   import sop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic wp_n = 1'b0;
   logic arr = 1'b0;
   sop_cmd_type cmd;
   logic [7:0] sp, sl, cp, cl, rd;
   logic rdv, rej, ego, eref, aref;
   int err_total = 0;
   int n_checks = 0;
   always #25 i_clk_sys = ~i_clk_sys;
   sop_host_model host_u (.i_clk_sys(i_clk_sys), .o_cmd(cmd));
   sop_status1_nv dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_cmd(cmd), .i_write_protect_n(wp_n), .i_array_op_req(arr),
      .o_status_persist(sp), .o_status_live(sl), .o_config_persist(cp),
      .o_config_live(cl), .o_rd_data(rd), .o_rd_valid(rdv),
      .o_wr_rejected(rej), .o_erase_go(ego), .o_erase_refused(eref),
      .o_array_op_refused(aref));
   // *****
   // Tasks
   // *****
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Flags packed as rejected, erase go, erase refused, array refused
   task automatic flags(input logic [3:0] exp);
      chk({4'h0, rej, ego, eref, aref}, {4'h0, exp});
   endtask : flags
   task automatic wr(input logic [7:0] sd, input logic [7:0] cd,
      input logic hc);
      host_u.issue(OP_WRITE_REGS, 2'h0, sd, cd, hc);
   endtask : wr
   task automatic wrany(input logic [1:0] s, input logic [7:0] sd,
      input logic [7:0] cd);
      host_u.issue(OP_WRITE_ANY, s, sd, cd, 1'b0);
   endtask : wrany
   task automatic rdany(input logic [1:0] s, input logic [7:0] exp);
      host_u.issue(OP_READ_ANY, s, 8'h00, 8'h00, 1'b0);
      chk({7'h00, rdv}, 8'h01);
      chk(rd, exp);
   endtask : rdany
   task automatic give_verdict();
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // *****
   // Sequence
   // *****
   initial begin
      repeat (20) @(negedge i_clk_sys);
      i_reset = 1'b0;
      @(negedge i_clk_sys);
      for (int s = 0; s < 4; s++) rdany(s[1:0], 8'h00);
      wr(8'hff, 8'h00, 1'b0);
      chk(sp, 8'h9c);
      chk(sl, 8'h9c);
      wr(8'h00, 8'h00, 1'b0);
      flags(4'h8);
      wrany(SEL_CONFIG1_PERSIST, 8'hff, 8'hff);
      flags(4'h8);
      chk(cp, 8'h00);
      chk(sp, 8'h9c);
      arr = 1'b1;
      @(negedge i_clk_sys);
      arr = 1'b0;
      flags(4'h1);
      host_u.issue(OP_WHOLE_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
      flags(4'h2);
      wp_n = 1'b1;
      wr(8'h80, 8'h00, 1'b0);
      chk(sp, 8'h80);
      host_u.issue(OP_WHOLE_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
      flags(4'h4);
      wr(8'h80, 8'h08, 1'b1);
      chk(cp, 8'h08);
      chk(sp, 8'h9c);
      wr(8'h84, 8'h00, 1'b0);
      chk(sp, 8'h9c);
      chk(sl, 8'h84);
      host_u.issue(OP_WHOLE_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
      flags(4'h2);
      wrany(SEL_STATUS1_LIVE, 8'h88, 8'h00);
      chk(sl, 8'h88);
      chk(sp, 8'h9c);
      wrany(SEL_CONFIG1_LIVE, 8'h00, 8'h0a);
      chk(cl, 8'h0a);
      chk(cp, 8'h08);
      // Persistent cells must survive a reset in mid-run
      i_reset = 1'b1;
      repeat (20) @(negedge i_clk_sys);
      i_reset = 1'b0;
      @(negedge i_clk_sys);
      chk(sl, 8'h9c);
      chk(cl, 8'h08);
      rdany(SEL_STATUS1_PERSIST, 8'h9c);
      give_verdict();
   end
endmodule : sop_status1_nv_tb_top
`default_nettype wire
